/* verilog/dtr_host_regs.sv */
// host register bank of the tone transceiver
`timescale 1ns/100ps
`include "dtr_params.svh"
module dtr_host_regs (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic cs_n_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic register_select_line_i,
   input wire logic [3:0] data_i,
   output logic [3:0] data_o,
   output logic data_oe_o,
   input wire logic rx_valid_i,
   input wire logic [3:0] rx_code_i,
   input wire logic steer_delayed_i,
   input wire logic tone_absent_i,
   input wire logic progress_detect_i,
   output logic event_pin_o,
   output logic event_pin_oe_o,
   output logic [3:0] tx_code_o,
   output logic tone_active_o,
   output logic single_tone_o,
   output logic column_tone_o,
   output logic progress_mode_o
);
   // ****************
   // access decode
   // ****************
   logic [3:0] control_reg_a_reg;
   logic [3:0] control_reg_b_reg;
   logic [3:0] rx_code_reg;
   logic [3:0] tx_code_reg;
   logic [3:0] flags_reg;
   logic [3:0] flags_next;
   logic redirect_reg;
   logic rd_d_reg;
   logic wr_d_reg;
   logic sel;
   logic rd_fall;
   logic wr_fall;
   logic wr_tx;
   logic wr_ctrl;
   logic rd_rx;
   logic rd_stat;
   logic status_read;
   assign sel = !cs_n_i;
   assign rd_fall = sel && !rd_n_i && rd_d_reg;
   assign wr_fall = sel && !wr_n_i && wr_d_reg;
   assign wr_tx = wr_fall && (register_select_line_i == `DTR_ADDR_DATA);
   assign wr_ctrl = wr_fall && (register_select_line_i == `DTR_ADDR_CTRL);
   assign rd_rx = sel && !rd_n_i && (register_select_line_i == `DTR_ADDR_DATA);
   assign rd_stat = sel && !rd_n_i && (register_select_line_i == `DTR_ADDR_CTRL);
   assign status_read = rd_fall && (register_select_line_i == `DTR_ADDR_CTRL);
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rd_d_reg <= 1'b1;
         wr_d_reg <= 1'b1;
      end else if (ce_i) begin
         rd_d_reg <= rd_n_i || cs_n_i;
         wr_d_reg <= wr_n_i || cs_n_i;
      end
   end
   // ****************
   // control registers
   // ****************
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         control_reg_a_reg <= `DTR_CTRL_RESET;
         control_reg_b_reg <= `DTR_CTRL_RESET;
         redirect_reg <= 1'b0;
         tx_code_reg <= 4'h0;
      end else if (ce_i) begin
         if (wr_tx) tx_code_reg <= data_i;
         if (wr_ctrl) begin
            if (redirect_reg) begin
               control_reg_b_reg <= data_i;
               redirect_reg <= 1'b0;
            end else begin
               control_reg_a_reg <= data_i;
               redirect_reg <= data_i[`DTR_CRA_REDIRECT];
            end
         end
      end
   end
   // ****************
   // tone generation control
   // ****************
   logic tone_en;
   logic prog_mode;
   logic irq_en;
   logic burst_mode;
   logic burst_tone;
   logic tx_done;
   assign tone_en = control_reg_a_reg[`DTR_CRA_TONE_EN];
   assign prog_mode = control_reg_a_reg[`DTR_CRA_PROG_MODE];
   assign irq_en = control_reg_a_reg[`DTR_CRA_IRQ_EN];
   assign burst_mode = !control_reg_b_reg[`DTR_CRB_BURST_OFF];
   dtr_burst_timer u_timer (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .start_i(wr_tx),
      .enable_i(burst_mode && tone_en),
      .double_i(prog_mode),
      .tone_on_o(burst_tone),
      .done_o(tx_done)
   );
   // burst gates tone, otherwise the enable bit holds it on
   assign tone_active_o = tone_en && (burst_mode ? burst_tone : 1'b1);
   assign single_tone_o = control_reg_b_reg[`DTR_CRB_SINGLE];
   assign column_tone_o = control_reg_b_reg[`DTR_CRB_COLUMN];
   assign progress_mode_o = prog_mode;
   assign tx_code_o = tx_code_reg;
   // ****************
   // receive code and status flags
   // ****************
   logic rx_take;
   assign rx_take = rx_valid_i && !prog_mode;
   always_comb begin
      flags_next = flags_reg;
      if (status_read) begin
         flags_next[`DTR_ST_TX_READY] = 1'b0;
         flags_next[`DTR_ST_RX_FULL] = 1'b0;
      end
      if (!burst_mode) flags_next[`DTR_ST_TX_READY] = 1'b0;
      if (tx_done) flags_next[`DTR_ST_TX_READY] = 1'b1;
      if (rx_take) flags_next[`DTR_ST_RX_FULL] = 1'b1;
      if (rx_valid_i) flags_next[`DTR_ST_ABSENT] = 1'b0;
      if (tone_absent_i) flags_next[`DTR_ST_ABSENT] = 1'b1;
      flags_next[`DTR_ST_IRQ] = flags_next[`DTR_ST_TX_READY] || flags_next[`DTR_ST_RX_FULL];
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rx_code_reg <= 4'h0;
         flags_reg <= 4'h0;
      end else if (ce_i) begin
         if (rx_take) rx_code_reg <= rx_code_i;
         flags_reg <= flags_next;
      end
   end
   // ****************
   // data bus and event pin
   // ****************
   logic [3:0] rd_mux;
   logic pin_low;
   assign rd_mux = (register_select_line_i == `DTR_ADDR_CTRL) ? flags_reg : rx_code_reg;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) data_o <= 4'h0;
      else if (ce_i && rd_fall) data_o <= rd_mux;
   end
   assign data_oe_o = rd_rx || rd_stat;
   // pin low: interrupt, or inverted delayed steering, or progress square wave
   assign pin_low = control_reg_b_reg[`DTR_CRB_TEST] ? steer_delayed_i :
                    prog_mode ? (irq_en && !progress_detect_i) :
                    (irq_en && flags_reg[`DTR_ST_IRQ]);
   assign event_pin_o = 1'b0;
   assign event_pin_oe_o = pin_low;
   // ****************
   // checks
   // ****************
   chk_redirect_once: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && wr_ctrl && redirect_reg) |=> !redirect_reg)
      else $error("control B redirect not single shot");
   chk_redirect_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && wr_ctrl && !redirect_reg && data_i[3])
      |=> redirect_reg && control_reg_a_reg == $past(data_i))
      else $error("control A write did not arm redirect");
   chk_tx_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && wr_tx) |=> tx_code_reg == $past(data_i))
      else $error("transmit code not loaded");
   chk_rx_full: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && rx_take) |=> flags_reg[2] && flags_reg[0] && rx_code_reg == $past(rx_code_i))
      else $error("receive full flag or code wrong");
   chk_read_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && status_read && !rx_take && !tx_done) |=> !flags_reg[0])
      else $error("status read did not clear");
   chk_absent_keep: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && status_read && flags_reg[3] && !rx_valid_i) |=> flags_reg[3])
      else $error("status read disturbed absent flag");
   chk_no_burst_rdy: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && !burst_mode && !tx_done) |=> !flags_reg[1])
      else $error("ready flag outside burst mode");
   chk_pin_test: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      control_reg_b_reg[1] |-> (event_pin_oe_o == steer_delayed_i))
      else $error("test mode pin wrong");
   chk_bus_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      cs_n_i |-> !data_oe_o)
      else $error("bus driven while unselected");
   cov_ctrl_b: cover property (@(posedge mclk_i) ce_i && wr_ctrl && redirect_reg);
   cov_tx_done: cover property (@(posedge mclk_i) tx_done);
   cov_rx: cover property (@(posedge mclk_i) rx_take ##1 status_read);
endmodule

/* pkg/dtr_params.svh */
// constants for the tone transceiver host register bank
// Functional notes
// - select line plus strobe picks register access
// - receive code register is read-only
// - transmit code register is write-only
// - control B reached once after select bit
// - both control registers clear at reset
// - event pin flags receive or transmit-ready
// - event pin is open-drain, low or released
// - burst mode: tone, equal pause, then ready
// - call-progress mode doubles burst and pause
// - burst disabled: tone follows enable bit
// - test bit routes inverted steering to pin
// - control B bit 2 selects single tone
// - control B bit 3 picks row or column
// - status bit 0 summarises, read clears it
// - status bit 1 transmit ready, cleared
// - status bit 2 new receive code, read clears
// - status bit 3 tone absent, read-immune
// - burst and pause each 51 ms
// - control A bit 0 enables tone output
// - control A bit 1 selects call-progress mode
// - control A bit 2 enables interrupt mode
`ifndef DTR_PARAMS_SVH
`define DTR_PARAMS_SVH
`define DTR_ADDR_DATA 1'h0
`define DTR_ADDR_CTRL 1'h1
`define DTR_CRA_TONE_EN 0
`define DTR_CRA_PROG_MODE 1
`define DTR_CRA_IRQ_EN 2
`define DTR_CRA_REDIRECT 3
`define DTR_CRB_BURST_OFF 0
`define DTR_CRB_TEST 1
`define DTR_CRB_SINGLE 2
`define DTR_CRB_COLUMN 3
`define DTR_ST_IRQ 0
`define DTR_ST_TX_READY 1
`define DTR_ST_RX_FULL 2
`define DTR_ST_ABSENT 3
`define DTR_CTRL_RESET 4'h0
`define DTR_CLK_HZ 10000000
`define DTR_BURST_MS 51
`define DTR_BURST_CYC ((`DTR_BURST_MS * `DTR_CLK_HZ) / 1000)
`endif

/* pkg/dtr_pkg.sv */
// types for the tone transceiver host register bank
package dtr_pkg;
   typedef enum logic [1:0] {
      DTR_IDLE = 2'b00,
      DTR_BURST = 2'b01,
      DTR_PAUSE = 2'b10
   } dtr_burst_t;
endpackage

/* verilog/dtr_burst_timer.sv */
// burst and pause sequencer for the tone generator
`timescale 1ns/100ps
`include "dtr_params.svh"
module dtr_burst_timer (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic enable_i,
   input wire logic double_i,
   output logic tone_on_o,
   output logic done_o
);
   localparam logic [21:0] BURST_CYC = 22'(`DTR_BURST_CYC);
   dtr_pkg::dtr_burst_t state_reg;
   dtr_pkg::dtr_burst_t state_next;
   logic [21:0] cnt_reg;
   logic [21:0] limit;
   logic expired;
   assign limit = double_i ? 22'(2 * BURST_CYC) : BURST_CYC;
   assign expired = (cnt_reg >= limit - 22'h1);
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         dtr_pkg::DTR_IDLE: if (start_i && enable_i) state_next = dtr_pkg::DTR_BURST;
         dtr_pkg::DTR_BURST: if (expired) state_next = dtr_pkg::DTR_PAUSE;
         dtr_pkg::DTR_PAUSE: if (expired) state_next = dtr_pkg::DTR_IDLE;
         default: state_next = dtr_pkg::DTR_IDLE;
      endcase
      if (!enable_i) state_next = dtr_pkg::DTR_IDLE;
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_reg <= dtr_pkg::DTR_IDLE;
         cnt_reg <= 22'h0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         cnt_reg <= (state_next != state_reg) ? 22'h0 : cnt_reg + 22'h1;
         done_o <= enable_i && (state_reg == dtr_pkg::DTR_PAUSE) && expired;
      end
   end
   assign tone_on_o = (state_reg == dtr_pkg::DTR_BURST);
   chk_burst_len: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (state_reg == dtr_pkg::DTR_BURST && cnt_reg > 22'h0) |-> cnt_reg < limit)
      else $error("burst ran past its length");
endmodule

/* verif/dtr_host_model.sv */
// host processor model driving the parallel register port
`timescale 1ns/100ps
module dtr_host_model (
   input wire logic mclk_i,
   input wire logic [3:0] bus_i,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic rs_o,
   output logic drive_o,
   output logic [3:0] data_o
);
   initial begin
      cs_n_o = 1'b1;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
      rs_o = 1'b0;
      drive_o = 1'b0;
      data_o = 4'h0;
   end
   // one access: strobe held two edges, sampled, then released
   task automatic acc(input logic sel, input logic wr, input logic [3:0] d,
                      input logic cs_on, output logic [3:0] q);
      @(posedge mclk_i);
      cs_n_o <= ~cs_on;
      rs_o <= sel;
      rd_n_o <= wr;
      wr_n_o <= ~wr;
      drive_o <= wr;
      data_o <= d;
      repeat (2) @(posedge mclk_i);
      q = bus_i;
      cs_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      drive_o <= 1'b0;
      data_o <= ~d;
      @(posedge mclk_i);
   endtask
   // start-up clearing of both control registers
   task automatic init();
      logic [3:0] q;
      acc(1'b1, 1'b1, 4'h8, 1'b1, q);
      acc(1'b1, 1'b1, 4'h0, 1'b1, q);
      acc(1'b1, 1'b1, 4'h0, 1'b1, q);
   endtask
endmodule

/* verif/tb.sv */
// self-checking bench for the host register bank
`timescale 1ns/100ps
`define CHK(a, b) begin \
   check_count++; \
   if ((a) !== (b)) begin \
      fails++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
   end \
end
module tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic rx_valid = 1'b0;
   logic [3:0] rx_code = 4'h0;
   logic steer = 1'b0;
   logic absent = 1'b0;
   logic prog = 1'b1;
   logic cs_n, rd_n, wr_n, rs, hdrv, dev_oe, pin, pin_oe, tone, single, column, pmode;
   logic [3:0] hd, dev_d, tx_code;
   wire [3:0] bus = hdrv ? hd : (dev_oe ? dev_d : 4'hF);
   int fails = 0;
   int check_count = 0;
   always #50 mclk = ~mclk;
   dtr_host_model host (.mclk_i(mclk), .bus_i(bus), .cs_n_o(cs_n), .rd_n_o(rd_n),
      .wr_n_o(wr_n), .rs_o(rs), .drive_o(hdrv), .data_o(hd));
   dtr_host_regs uut (.mclk_i(mclk), .rst_n_i(rst_n), .ce_i(1'b1), .cs_n_i(cs_n),
      .rd_n_i(rd_n), .wr_n_i(wr_n), .register_select_line_i(rs), .data_i(bus),
      .data_o(dev_d), .data_oe_o(dev_oe), .rx_valid_i(rx_valid), .rx_code_i(rx_code),
      .steer_delayed_i(steer), .tone_absent_i(absent), .progress_detect_i(prog),
      .event_pin_o(pin), .event_pin_oe_o(pin_oe), .tx_code_o(tx_code),
      .tone_active_o(tone), .single_tone_o(single), .column_tone_o(column),
      .progress_mode_o(pmode));
   task automatic wr(input logic sel, input logic [3:0] d);
      logic [3:0] q;
      host.acc(sel, 1'b1, d, 1'b1, q);
   endtask
   task automatic rd(input logic sel, input logic [3:0] exp);
      logic [3:0] q;
      host.acc(sel, 1'b0, 4'h0, 1'b1, q);
      `CHK(q, exp)
   endtask
   task automatic pulse(input logic is_rx, input logic [3:0] c);
      @(posedge mclk);
      rx_valid <= is_rx;
      absent <= ~is_rx;
      rx_code <= c;
      @(posedge mclk);
      rx_valid <= 1'b0;
      absent <= 1'b0;
      rx_code <= ~c;
      repeat (2) @(posedge mclk);
   endtask
   task automatic t_reset();
      `CHK({tone, pmode, single, column, pin_oe}, 5'h00)
      rd(1'b1, 4'h0);
   endtask
   task automatic t_data();
      pulse(1'b1, 4'h9);
      rd(1'b0, 4'h9);
      wr(1'b0, 4'h3);
      `CHK(tx_code, 4'h3)
      rd(1'b0, 4'h9);
      rd(1'b1, 4'h5);
      rd(1'b1, 4'h0);
      pulse(1'b0, 4'h0);
      rd(1'b1, 4'h8);
      rd(1'b1, 4'h8);
      pulse(1'b1, 4'h2);
      rd(1'b1, 4'h5);
   endtask
   task automatic t_ctrl();
      wr(1'b1, 4'h8);
      wr(1'b1, 4'hD);
      wr(1'b1, 4'h1);
      `CHK({tone, single, column}, 3'h7)
      wr(1'b1, 4'h2);
      `CHK({tone, pmode, single}, 3'h3)
      host.init();
   endtask
   task automatic t_event();
      wr(1'b1, 4'h4);
      pulse(1'b1, 4'h6);
      `CHK({pin_oe, pin}, 2'h2)
      rd(1'b1, 4'h5);
      `CHK(pin_oe, 1'b0)
      host.init();
      wr(1'b1, 4'h8);
      wr(1'b1, 4'h2);
      @(posedge mclk);
      steer <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK(pin_oe, 1'b1)
      steer <= 1'b0;
      repeat (2) @(posedge mclk);
      `CHK(pin_oe, 1'b0)
      host.init();
      wr(1'b1, 4'h6);
      prog <= 1'b0;
      repeat (2) @(posedge mclk);
      `CHK({pmode, pin_oe}, 2'h3)
      prog <= 1'b1;
      repeat (2) @(posedge mclk);
      `CHK(pin_oe, 1'b0)
      host.init();
   endtask
   task automatic t_burst();
      logic [3:0] q;
      wr(1'b1, 4'h1);
      wr(1'b0, 4'h7);
      `CHK({tone, tx_code}, 5'h17)
      repeat (300) @(posedge mclk);
      `CHK(tone, 1'b1)
      host.acc(1'b0, 1'b1, 4'hA, 1'b0, q);
      `CHK(tx_code, 4'h7)
   endtask
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #2_000_000;
      fails++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      host.init();
      t_data();
      t_ctrl();
      t_event();
      t_burst();
      end_of_test();
   end
endmodule
